// ---- core/nhc_map.vh ----
`ifndef NHC_MAP_VH
`define NHC_MAP_VH
`define NHC_CMD_READ_A   8'h00
`define NHC_CMD_READ_B   8'h01
`define NHC_CMD_READ_C   8'h50
`define NHC_CMD_READ_ID  8'h90
`define NHC_CMD_RESET    8'hFF
`define NHC_CMD_PROG     8'h80
`define NHC_CMD_PROG_GO  8'h10
`define NHC_CMD_ERASE    8'h60
`define NHC_CMD_ERASE_GO 8'hD0
`define NHC_CMD_STATUS   8'h70
`define NHC_OP_CMD       2'h0
`define NHC_OP_ADDR      2'h1
`define NHC_OP_WDATA     2'h2
`define NHC_OP_RDATA     2'h3
`define NHC_MAIN_NOP     2
`define NHC_SPARE_NOP    3
`define NHC_CLK_MHZ      20
`define NHC_RST_BUSY_US  5
`define NHC_RST_BUSY_CYC (`NHC_RST_BUSY_US * `NHC_CLK_MHZ)
`define NHC_HALF_CYC     2
`endif

// ---- core/nhc_fifo.v ----
`timescale 1ns/1ns
module nhc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             i_ref_clk,
  input  wire             i_rstn,
  // Fill side
  input  wire             i_valid,
  output wire             o_ready,
  input  wire [WIDTH-1:0] i_data,
  // Drain side
  output wire             o_valid,
  input  wire             i_ready,
  output wire [WIDTH-1:0] o_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp;
  reg [AW-1:0]    rp;
  reg [AW:0]      cnt;
  wire            push;
  wire            pop;
  assign o_ready = (cnt != DEPTH[AW:0]);
  assign o_valid = (cnt != {(AW+1){1'b0}});
  assign o_data  = mem[rp];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  always @(posedge i_ref_clk) begin
    if (push) begin
      mem[wp] <= i_data;
    end
  end
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // nhc_fifo

// ---- core/nhc_host.v ----
`timescale 1ns/1ns
`include "nhc_map.vh"
module nhc_host #(
  parameter HALF = `NHC_HALF_CYC
) (
  // Clock and reset
  input  wire       i_ref_clk,
  input  wire       i_rstn,
  // User request: op code and byte
  input  wire       i_req_valid,
  output reg        o_req_ready,
  input  wire [1:0] i_req_op,
  input  wire [7:0] i_req_byte,
  input  wire       i_req_spare,
  // Read data out
  output reg        o_rd_valid,
  output reg  [7:0] o_rd_byte,
  // Status
  output reg        o_busy_seen,
  output reg        o_refused,
  // Flash pins
  output reg        o_ce_n,
  output reg        o_cle,
  output reg        o_ale,
  output reg        o_we_n,
  output reg        output_strobe_n,
  output reg        o_wp_n,
  output reg  [7:0] o_io,
  output reg        o_io_oe_n,
  input  wire [7:0] i_io,
  input  wire       i_ready_busy_n
);
  // ---------------------------------------------
  // Request buffer
  // ---------------------------------------------
  wire       f_valid;
  reg        f_take;
  wire [10:0] f_data;
  wire       f_ready;
  nhc_fifo #(.WIDTH(11), .DEPTH(4), .AW(2)) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_valid   (i_req_valid),
    .o_ready   (f_ready),
    .i_data    ({i_req_spare, i_req_op, i_req_byte}),
    .o_valid   (f_valid),
    .i_ready   (f_take),
    .o_data    (f_data)
  );
  // ---------------------------------------------
  // Strobe sequencer
  // ---------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_LOW  = 2'h1;
  localparam ST_HIGH = 2'h2;
  reg [1:0] state;
  reg [7:0] cnt;
  reg [1:0] op;
  reg [7:0] last_cmd;
  reg [1:0] main_cnt;
  reg [1:0] spare_cnt;
  reg       spare_prog;
  reg       prog_ok;
  reg       cmd_known;
  always @* begin
    f_take = (state == ST_IDLE) && f_valid && i_ready_busy_n;
    cmd_known = (f_data[9:8] != `NHC_OP_CMD) ||
                (f_data[7:0] == `NHC_CMD_READ_A) ||
                (f_data[7:0] == `NHC_CMD_READ_B) ||
                (f_data[7:0] == `NHC_CMD_READ_C) ||
                (f_data[7:0] == `NHC_CMD_READ_ID) ||
                (f_data[7:0] == `NHC_CMD_RESET) ||
                (f_data[7:0] == `NHC_CMD_PROG) ||
                (f_data[7:0] == `NHC_CMD_PROG_GO) ||
                (f_data[7:0] == `NHC_CMD_ERASE) ||
                (f_data[7:0] == `NHC_CMD_ERASE_GO) ||
                (f_data[7:0] == `NHC_CMD_STATUS);
  end
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      op <= 2'h0;
      last_cmd <= 8'h00;
      main_cnt <= 2'h0;
      spare_cnt <= 2'h0;
      spare_prog <= 1'b0;
      prog_ok <= 1'b0;
      o_req_ready <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_byte <= 8'h00;
      o_busy_seen <= 1'b0;
      o_refused <= 1'b0;
      o_ce_n <= 1'b1;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      output_strobe_n <= 1'b1;
      o_wp_n <= 1'b0;
      o_io <= 8'h00;
      o_io_oe_n <= 1'b1;
    end else begin
      o_req_ready <= f_ready;
      o_rd_valid <= 1'b0;
      o_refused <= 1'b0;
      o_busy_seen <= ~i_ready_busy_n;
      case (state)
        ST_IDLE: begin
          // Strobe stays high while busy, and chip select stays low.
          output_strobe_n <= 1'b1;
          o_we_n <= 1'b1;
          if (f_take && !cmd_known) begin
            // Undefined codes are dropped here and never reach the pins.
            o_refused <= 1'b1;
            o_wp_n <= 1'b0;
          end else if (f_take) begin
            op <= f_data[9:8];
            o_ce_n <= 1'b0;
            o_cle <= (f_data[9:8] == `NHC_OP_CMD);
            o_ale <= (f_data[9:8] == `NHC_OP_ADDR);
            o_io <= f_data[7:0];
            cnt <= HALF[7:0];
            state <= ST_LOW;
            if (f_data[9:8] == `NHC_OP_CMD) begin
              last_cmd <= f_data[7:0];
              if (f_data[7:0] == `NHC_CMD_PROG) begin
                spare_prog <= f_data[10];
                // One main and one spare pass count, shared by all pages, guard partial programs.
                prog_ok <= f_data[10] ?
                  (spare_cnt < `NHC_SPARE_NOP) :
                  (main_cnt < `NHC_MAIN_NOP);
              end
              if (f_data[7:0] == `NHC_CMD_ERASE_GO) begin
                main_cnt <= 2'h0;
                spare_cnt <= 2'h0;
              end
              if (f_data[7:0] == `NHC_CMD_PROG_GO && prog_ok) begin
                if (spare_prog) begin
                  spare_cnt <= spare_cnt + 2'h1;
                end else begin
                  main_cnt <= main_cnt + 2'h1;
                end
              end
            end
            // Write protect lifts for address and data cycles and for a permitted program or erase.
            // Bad blocks are screened by the caller, so erase and erase confirm open it unguarded.
            o_wp_n <= (f_data[7:0] == `NHC_CMD_ERASE) ||
                      (f_data[9:8] != `NHC_OP_CMD) ||
                      (f_data[7:0] == `NHC_CMD_PROG_GO && prog_ok) ||
                      (f_data[7:0] == `NHC_CMD_ERASE_GO);
            if (f_data[9:8] == `NHC_OP_RDATA) begin
              o_io_oe_n <= 1'b1;
              output_strobe_n <= 1'b0;
            end else begin
              o_io_oe_n <= 1'b0;
              o_we_n <= 1'b0;
            end
            if (f_data[9:8] == `NHC_OP_CMD &&
                f_data[7:0] == `NHC_CMD_PROG_GO && !prog_ok) begin
              o_refused <= 1'b1;
            end
          end
        end
        ST_LOW: begin
          if (cnt == 8'h00) begin
            if (op == `NHC_OP_RDATA) begin
              o_rd_byte <= i_io;
              o_rd_valid <= 1'b1;
            end
            o_we_n <= 1'b1;
            output_strobe_n <= 1'b1;
            cnt <= HALF[7:0];
            state <= ST_HIGH;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          // A busy device must see both latch enables low at once.
          if (!i_ready_busy_n) begin
            o_cle <= 1'b0;
            o_ale <= 1'b0;
          end
          if (cnt == 8'h00) begin
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_io_oe_n <= 1'b1;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
      endcase
    end
  end
endmodule // nhc_host

// ---- tb/nhc_properties.sv ----
`timescale 1ns/1ns
module nhc_props(input wire logic i_ref_clk, i_rstn, o_ce_n, o_cle, o_ale,
  o_we_n, output_strobe_n, o_wp_n, o_io_oe_n, o_busy_seen, o_rd_valid,
  o_refused,
  input wire logic [7:0] o_io);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_pulse(s); !s [*3] ##1 s; endsequence
  AST_EXCL:
    assert property (!(o_cle && o_ale)) else $error("cle ale");
  AST_WE:
    assert property ($fell(o_we_n) |-> s_pulse(o_we_n)) else $error("we");
  AST_RD:
    assert property ($fell(output_strobe_n) |-> s_pulse(output_strobe_n)
      ##0 o_rd_valid) else $error("rd");
  AST_GAP:
    assert property ($rose(o_we_n) |-> o_we_n [*4]) else $error("gap");
  AST_DRV:
    assert property (!o_we_n |-> !o_io_oe_n ##1 (o_we_n || $stable(o_io)))
      else $error("drv");
  AST_REL:
    assert property (!output_strobe_n |-> o_io_oe_n && o_we_n)
      else $error("rel");
  AST_WP:
    assert property ($fell(o_we_n) && o_cle && o_io < 8'h02 |-> !o_wp_n)
      else $error("wp");
  AST_BUSY:
    assert property (o_busy_seen |-> o_we_n && output_strobe_n && !o_ce_n
      && !o_cle && !o_ale) else $error("busy");
  AST_NOPROG:
    assert property (o_refused |-> !o_wp_n) else $error("refused");
  AST_RDV:
    assert property (o_rd_valid |-> $past(!output_strobe_n))
      else $error("rdv");
endmodule // nhc_props
bind nhc_host nhc_props u_props(.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
  .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n),
  .output_strobe_n(output_strobe_n), .o_wp_n(o_wp_n),
  .o_io_oe_n(o_io_oe_n), .o_busy_seen(o_busy_seen),
  .o_rd_valid(o_rd_valid), .o_refused(o_refused), .o_io(o_io));

// ---- tb/nhc_flash_model.sv ----
`timescale 1ns/1ns
module nhc_flash_model #(parameter int RST_NS = 1000, OP_NS = 400)(
  input wire logic ce_n, cle, ale, we_n, re_n, wp_n,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic rb_n);
  logic [7:0] cmd;
  logic half;
  int ac, ptr;
  initial begin
    rb_n = 1;
    io_out = 8'h5A;
  end
  task go_busy(int ns);
    rb_n = 0;
    rb_n <= #(ns) 1'b1;
  endtask
  always @(posedge we_n) if (!ce_n && cle) begin
    cmd = io_in;
    half = (io_in == 8'h01);
    ac = 0;
    ptr = 0;
    if (io_in == 8'hFF) go_busy(RST_NS);
    if (wp_n && (io_in == 8'h10 || io_in == 8'hD0)) go_busy(OP_NS);
  end else if (!ce_n && ale) begin
    ac++;
    if (ac == 3 && cmd < 8'h02) go_busy(OP_NS);
  end
  always @(negedge re_n) begin
    io_out = {half, ptr[6:0]};
    ptr++;
  end
  // Released bus shows the inverse so a late sample cannot pass.
  always @(posedge re_n) io_out = ~io_out;
endmodule // nhc_flash_model

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`include "nhc_map.vh"
module tb;
  logic clk = 0, rstn = 0, vld = 0, spr = 0;
  logic [1:0] op = 0;
  logic [7:0] byt = 0;
  wire rdy, rdv, bsy, refp, ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb_n;
  wire [7:0] rdb, io, mio;
  wire [7:0] bus = oe_n ? mio : io;
  int fail_count = 0, total_checks = 0, nref = 0;
  logic [7:0] rdq[$];
  logic [7:0] rc[4] = '{8'h01, 8'h00, 8'h01, 8'h50};
  nhc_host dut(.i_ref_clk(clk), .i_rstn(rstn), .i_req_valid(vld),
    .o_req_ready(rdy), .i_req_op(op), .i_req_byte(byt), .i_req_spare(spr),
    .o_rd_valid(rdv), .o_rd_byte(rdb), .o_busy_seen(bsy), .o_refused(refp),
    .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n),
    .output_strobe_n(re_n), .o_wp_n(wp_n), .o_io(io), .o_io_oe_n(oe_n),
    .i_io(bus), .i_ready_busy_n(rb_n));
  nhc_flash_model fm(.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .io_in(bus), .io_out(mio), .rb_n(rb_n));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    if (rdv) rdq.push_back(rdb);
    if (refp) nref++;
  end
  function logic [7:0] exp_rd(bit h, int i);
    return {h, i[6:0]};
  endfunction
  task chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task push(logic [1:0] o, logic [7:0] b, logic s = 0);
    for (int k = 0; k < 3000 && rdy !== 1'b1; k++) @(negedge clk);
    if (rdy !== 1'b1) fail_count++;
    {op, byt, spr, vld} = {o, b, s, 1'b1};
    @(negedge clk);
    vld = 0;
    @(negedge clk);
  endtask
  task idle;
    int k;
    k = 0;
    repeat (3000) begin
      @(negedge clk);
      k = (rb_n && rdy && we_n && re_n) ? k + 1 : 0;
      if (k > 9) break;
    end
    if (k <= 9) fail_count++;
  endtask
  task cmd3(logic [7:0] c, logic s = 0);
    push(`NHC_OP_CMD, c, s);
    repeat (3) push(`NHC_OP_ADDR, 8'($urandom));
  endtask
  task prog(logic s);
    cmd3(8'h80, s);
    repeat (2) push(`NHC_OP_WDATA, 8'($urandom));
    push(`NHC_OP_CMD, 8'h10);
    idle;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(67125));
    repeat (4) @(negedge clk);
    rstn = 1;
    push(`NHC_OP_CMD, 8'hFF);
    repeat (4) push(`NHC_OP_CMD, 8'h70);
    chk("fifo ready", 8'(rdy), 8'h00);
    chk("busy seen", 8'(bsy), 8'h01);
    idle;
    chk("drained", 8'(bsy), 8'h00);
    foreach (rc[j]) begin
      rdq.delete();
      cmd3(rc[j]);
      idle;
      repeat (2) push(`NHC_OP_RDATA, 8'h00);
      idle;
      chk("read count", 8'(rdq.size()), 8'h02);
      for (int i = 0; i < 2; i++)
        chk("rd", rdq[i], exp_rd(rc[j] == 1, i));
    end
    repeat (3) prog(0);
    chk("main refusals", 8'(nref), 8'h01);
    cmd3(8'h60);
    push(`NHC_OP_CMD, 8'hD0);
    idle;
    repeat (4) prog(1);
    prog(0);
    chk("spare refusals", 8'(nref), 8'h02);
    push(`NHC_OP_CMD, 8'h3C);
    idle;
    chk("undefined refusals", 8'(nref), 8'h03);
    end_sim;
  end
  initial begin
    #1000000;
    fail_count++;
    end_sim;
  end
endmodule // tb
